// ==== hdl/irq_pulse_gen.sv ====
// Behaviour
// R1 - active modes: low pulse, then release; the code keeps driving the pin high after the pulse instead
// R2 - keep pin high guard interval between pulses
// R3 - pulse never changes operating mode
// R4 - class bit: wake-only or global sources
// R5 - wake events count only when enabled
// R6 - timeout flag is wake; own mask wins
// R7 - global adds failures; level status never
// R8 - mode-forcing faults and power-on never interrupt
// R9 - stop entry with wake bits set pulses
// R10 - readable status refreshed at pulse fall
// R11 - events stay latched until cleared
// R12 - host rereads status after clearing
// R13 - init mode: filter pin, pick configuration
// R14 - events during pulse or guard pend
//
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
module irq_pulse_gen #(
  parameter logic [irq_pulse_pkg::CNT_W-1:0] PULSE_CYCLES =
    irq_pulse_pkg::PULSE_CYCLES,
  parameter logic [irq_pulse_pkg::CNT_W-1:0] GUARD_CYCLES =
    irq_pulse_pkg::GUARD_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [irq_pulse_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [irq_pulse_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [irq_pulse_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [irq_pulse_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic mode_normal,
  input wire logic mode_stop,
  input wire logic mode_init,
  input wire logic stop_entry,
  input wire logic [irq_pulse_pkg::WAKE_W-1:0] wake_event_one,
  input wire logic [irq_pulse_pkg::WAKE_W-1:0] wake_event_two,
  input wire logic can_timeout_flag,
  input wire logic [irq_pulse_pkg::FAIL_W-1:0] fail_event,
  input wire logic int_in,
  output logic int_out,
  output logic int_oe_n,
  output logic hw_config,
  output logic irq
);

  localparam int CW = irq_pulse_pkg::CNT_W;
  localparam int WW = irq_pulse_pkg::WAKE_W;
  localparam int FW = irq_pulse_pkg::FAIL_W;

  irq_pulse_pkg::pulse_state_t state;
  irq_pulse_pkg::pulse_state_t next_state;

  logic int_global;
  logic can_timeout_irq_mask;
  logic [WW-1:0] wake_en_one;
  logic [WW-1:0] wake_en_two;
  logic [WW-1:0] wake_status_one;
  logic [WW-1:0] wake_status_two;
  logic [FW:0] fail_status;
  logic [WW-1:0] snap_one;
  logic [WW-1:0] snap_two;
  logic [FW:0] snap_fail;
  logic [irq_pulse_pkg::IRQ_W-1:0] irq_status;
  logic [irq_pulse_pkg::IRQ_W-1:0] irq_mask;
  logic pending;
  logic cfg_level;
  logic cfg_valid;

  logic aw_full;
  logic w_full;
  logic [irq_pulse_pkg::ADDR_W-1:0] aw_addr;
  logic [irq_pulse_pkg::DATA_W-1:0] w_data;
  logic [3:0] w_strb;

  // bus decode
  wire wr_do = ce && aw_full && w_full && !s_axi_bvalid;
  wire rd_do = ce && s_axi_arvalid && s_axi_arready;
  wire wr_hit = (aw_addr <= irq_pulse_pkg::OFF_LAST);
  wire rd_hit = (s_axi_araddr <= irq_pulse_pkg::OFF_LAST);
  wire [irq_pulse_pkg::ADDR_W-1:0] wa = {aw_addr[7:2], 2'h0};
  wire [irq_pulse_pkg::ADDR_W-1:0] ra = {s_axi_araddr[7:2], 2'h0};
  wire [31:0] lane = {{8{w_strb[3]}}, {8{w_strb[2]}},
                      {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [31:0] wbits = w_data & lane;
  wire wr_ctrl = wr_do && wa == irq_pulse_pkg::OFF_CTRL && w_strb[0];
  wire wr_en = wr_do && wa == irq_pulse_pkg::OFF_WAKE_EN;
  wire wr_mask = wr_do && wa == irq_pulse_pkg::OFF_IRQ_MASK && w_strb[0];
  wire [WW-1:0] clr_one =
    (wr_do && wa == irq_pulse_pkg::OFF_WAKE_ONE) ? wbits[WW-1:0] : '0;
  wire [WW-1:0] clr_two =
    (wr_do && wa == irq_pulse_pkg::OFF_WAKE_TWO) ? wbits[WW-1:0] : '0;
  wire [FW:0] clr_fail =
    (wr_do && wa == irq_pulse_pkg::OFF_FAIL) ? wbits[FW:0] : '0;
  wire rd_irq_clr = rd_do && ra == irq_pulse_pkg::OFF_IRQ_STAT;

  assign s_axi_awready = ce && !aw_full && !s_axi_bvalid;
  assign s_axi_wready = ce && !w_full && !s_axi_bvalid;
  assign s_axi_arready = ce && !s_axi_rvalid;

  // source qualification
  wire active = mode_normal || mode_stop;
  // R5 enabled wake only
  wire wake_q = |(wake_event_one & wake_en_one) ||
                |(wake_event_two & wake_en_two);
  // R6 own mask, class ignored
  wire cto_q = can_timeout_flag && !can_timeout_irq_mask;
  // R4 R7 failures only in global class
  // R8 mode-forcing faults have no path here
  wire fail_q = int_global && |fail_event;
  // R9 stop entry with wake bits left
  wire stop_q = stop_entry && (|wake_status_one || |wake_status_two);
  wire qual = active && (wake_q || cto_q || fail_q || stop_q);

  // pulse and guard sequencing
  wire tmr_done;
  wire tmr_busy;
  wire in_low = (state == irq_pulse_pkg::st_low);
  wire in_guard = (state == irq_pulse_pkg::st_guard);
  wire in_idle = (state == irq_pulse_pkg::st_idle);
  // R14 one more pulse after guard
  wire launch = active && pending &&
                (in_idle || (in_guard && tmr_done));
  wire tmr_start = launch || (in_low && tmr_done);
  wire [CW-1:0] tmr_len = in_low ? GUARD_CYCLES : PULSE_CYCLES;

  span_timer #(
    .WIDTH(CW)
  ) pulse_tmr (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .start(tmr_start),
    .len(tmr_len),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  always_comb
  begin
    next_state = state;
    unique case (state)
      irq_pulse_pkg::st_idle:
        if (launch)
          next_state = irq_pulse_pkg::st_low;
      irq_pulse_pkg::st_low:
        // R2 guard follows every pulse
        if (tmr_done)
          next_state = irq_pulse_pkg::st_guard;
      irq_pulse_pkg::st_guard:
        if (launch)
          next_state = irq_pulse_pkg::st_low;
        else if (tmr_done)
          next_state = irq_pulse_pkg::st_idle;
      default:
        next_state = irq_pulse_pkg::st_idle;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state <= irq_pulse_pkg::st_idle;
    else if (ce)
      state <= next_state;
  end

  // R14 new events win over launch
  wire next_pending = qual || (pending && !launch && active);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pending <= 1'b0;
    else if (ce)
      pending <= next_pending;
  end

  // R1 low pulse drive
  // R3 no mode output exists; pin only
  assign int_out = !in_low;
  // R13 pin released for sampling in init
  assign int_oe_n = mode_init;

  // R11 sticky latches, set wins over clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wake_status_one <= '0;
      wake_status_two <= '0;
      fail_status <= '0;
    end
    else if (ce)
    begin
      wake_status_one <= wake_event_one | (wake_status_one & ~clr_one);
      wake_status_two <= wake_event_two | (wake_status_two & ~clr_two);
      fail_status <= {can_timeout_flag, fail_event} |
                     (fail_status & ~clr_fail);
    end
  end

  // R10 readable copies refresh at pulse fall
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      snap_one <= '0;
      snap_two <= '0;
      snap_fail <= '0;
    end
    else if (ce)
    begin
      if (launch)
      begin
        snap_one <= wake_status_one & ~clr_one;
        snap_two <= wake_status_two & ~clr_two;
        snap_fail <= fail_status & ~clr_fail;
      end
      else
      begin
        snap_one <= snap_one & ~clr_one;
        snap_two <= snap_two & ~clr_two;
        snap_fail <= snap_fail & ~clr_fail;
      end
    end
  end

  // configuration pin filter
  wire filt_done;
  wire filt_busy;
  wire cfg_change = (int_in != cfg_level);
  // R13 restart filter on any pin change
  wire filt_start = mode_init && (cfg_change || (!cfg_valid && !filt_busy));
  wire cfg_take = mode_init && filt_done && !cfg_change;

  span_timer #(
    .WIDTH(CW)
  ) cfg_tmr (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .start(filt_start),
    .len(irq_pulse_pkg::CFG_FILT_CYCLES),
    .busy(filt_busy),
    .done(filt_done)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_level <= 1'b0;
      cfg_valid <= 1'b0;
      hw_config <= 1'b0;
    end
    else if (ce)
    begin
      cfg_level <= int_in;
      if (cfg_change)
        cfg_valid <= 1'b0;
      else if (cfg_take)
      begin
        cfg_valid <= 1'b1;
        hw_config <= cfg_level;
      end
    end
  end

  // software interrupt, cleared by reading
  wire [irq_pulse_pkg::IRQ_W-1:0] irq_set = {cfg_take, launch};
  wire [irq_pulse_pkg::IRQ_W-1:0] next_irq_status =
    irq_set | (irq_status & ~{irq_pulse_pkg::IRQ_W{rd_irq_clr}});
  assign irq = |(irq_status & irq_mask);

  // control registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      int_global <= irq_pulse_pkg::RST_GLOBAL;
      can_timeout_irq_mask <= irq_pulse_pkg::RST_CTO_MASK;
      wake_en_one <= irq_pulse_pkg::RST_WAKE_EN;
      wake_en_two <= irq_pulse_pkg::RST_WAKE_EN;
      irq_mask <= irq_pulse_pkg::RST_IRQ_MASK;
      irq_status <= '0;
    end
    else if (ce)
    begin
      irq_status <= next_irq_status;
      if (wr_ctrl)
      begin
        int_global <= w_data[irq_pulse_pkg::CTRL_GLOBAL_BIT];
        can_timeout_irq_mask <= w_data[irq_pulse_pkg::CTRL_CTO_MASK_BIT];
      end
      if (wr_en && w_strb[0])
        wake_en_one <= w_data[7:0];
      if (wr_en && w_strb[1])
        wake_en_two <= w_data[15:8];
      if (wr_mask)
        irq_mask <= w_data[irq_pulse_pkg::IRQ_W-1:0];
    end
  end

  // read mux
  wire [31:0] rd_val =
    (ra == irq_pulse_pkg::OFF_CTRL) ?
      {30'h0, can_timeout_irq_mask, int_global} :
    (ra == irq_pulse_pkg::OFF_WAKE_EN) ?
      {16'h0, wake_en_two, wake_en_one} :
    (ra == irq_pulse_pkg::OFF_WAKE_ONE) ? {24'h0, snap_one} :
    (ra == irq_pulse_pkg::OFF_WAKE_TWO) ? {24'h0, snap_two} :
    (ra == irq_pulse_pkg::OFF_FAIL) ? {23'h0, snap_fail} :
    (ra == irq_pulse_pkg::OFF_IRQ_STAT) ? {30'h0, irq_status} :
    (ra == irq_pulse_pkg::OFF_IRQ_MASK) ? {30'h0, irq_mask} :
    {27'h0, hw_config, pending, state};

  // write and read channels
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= irq_pulse_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= irq_pulse_pkg::RESP_OKAY;
      s_axi_rdata <= '0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_do)
      begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? irq_pulse_pkg::RESP_OKAY :
                                irq_pulse_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (rd_do)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_hit ? rd_val : '0;
        s_axi_rresp <= rd_hit ? irq_pulse_pkg::RESP_OKAY :
                                irq_pulse_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // checking helpers: cycles spent in the current phase
  logic [CW-1:0] low_len;
  logic [CW-1:0] guard_len;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      low_len <= '0;
      guard_len <= '0;
    end
    else if (ce)
    begin
      low_len <= in_low ? low_len + CW'(1) : '0;
      guard_len <= in_guard ? guard_len + CW'(1) : '0;
    end
  end

  property p_pulse_len;
    @(posedge aclk) disable iff (!aresetn)
    (ce && in_low && next_state != irq_pulse_pkg::st_low) |->
      low_len == PULSE_CYCLES - CW'(1);
  endproperty
  a_pulse_len: assert property (p_pulse_len) // R1
    else $error("pulse width wrong");

  property p_pin_drive;
    @(posedge aclk) disable iff (!aresetn)
    (in_low && !mode_init) |-> (!int_out && !int_oe_n);
  endproperty
  a_pin_drive: assert property (p_pin_drive) // R1
    else $error("pin not low during pulse");

  property p_guard_len;
    @(posedge aclk) disable iff (!aresetn)
    (ce && in_guard && next_state != irq_pulse_pkg::st_guard) |->
      guard_len == GUARD_CYCLES - CW'(1);
  endproperty
  a_guard_len: assert property (p_guard_len) // R2
    else $error("guard interval wrong");

  property p_init_release;
    @(posedge aclk) disable iff (!aresetn)
    mode_init |-> int_oe_n;
  endproperty
  a_init_release: assert property (p_init_release) // R13
    else $error("pin driven in init");

  property p_cto_pend;
    @(posedge aclk) disable iff (!aresetn)
    (ce && active && can_timeout_flag && !can_timeout_irq_mask) |=>
      pending;
  endproperty
  a_cto_pend: assert property (p_cto_pend) // R6
    else $error("timeout event lost");

  property p_global_fail;
    @(posedge aclk) disable iff (!aresetn)
    (ce && active && int_global && |fail_event) |=> pending;
  endproperty
  a_global_fail: assert property (p_global_fail) // R7
    else $error("global failure not pending");

  property p_stop_entry;
    @(posedge aclk) disable iff (!aresetn)
    (ce && active && stop_entry && |wake_status_one) |=> pending;
  endproperty
  a_stop_entry: assert property (p_stop_entry) // R9
    else $error("stop entry pulse missed");

  sequence s_launch;
    ce && launch && clr_one == '0;
  endsequence
  property p_snapshot;
    @(posedge aclk) disable iff (!aresetn)
    s_launch |=> snap_one == $past(wake_status_one);
  endproperty
  a_snapshot: assert property (p_snapshot) // R10
    else $error("snapshot not refreshed");

  property p_sticky;
    @(posedge aclk) disable iff (!aresetn)
    (ce && clr_two == '0) |=>
      (wake_status_two & $past(wake_status_two)) == $past(wake_status_two);
  endproperty
  a_sticky: assert property (p_sticky) // R11
    else $error("latched wake bit dropped");

  sequence s_guard_end_pending;
    ce && in_guard && tmr_done && pending && active;
  endsequence
  property p_retrigger;
    @(posedge aclk) disable iff (!aresetn)
    s_guard_end_pending |=> in_low;
  endproperty
  a_retrigger: assert property (p_retrigger) // R14
    else $error("pending pulse not issued");

endmodule // irq_pulse_gen

// ==== hdl/irq_pulse_pkg.sv ====
package irq_pulse_pkg;

  // clock and timing figures
  localparam int CLK_MHZ = 200;
  localparam int PULSE_US = 100;
  localparam int GUARD_US = 100;
  localparam int CFG_FILT_US = 7;
  localparam int CNT_W = 15;
  localparam logic [CNT_W-1:0] PULSE_CYCLES = CNT_W'(PULSE_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] GUARD_CYCLES = CNT_W'(GUARD_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] CFG_FILT_CYCLES =
    CNT_W'(CFG_FILT_US * CLK_MHZ);

  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int WAKE_W = 8;
  localparam int FAIL_W = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_WAKE_EN = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_WAKE_ONE = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_WAKE_TWO = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_FAIL = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_STATE = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_LAST = 8'h1c;

  // field positions
  localparam int CTRL_GLOBAL_BIT = 0;
  localparam int CTRL_CTO_MASK_BIT = 1;
  localparam int FAIL_CTO_BIT = 8;
  localparam int IRQ_PULSE_BIT = 0;
  localparam int IRQ_CFG_BIT = 1;
  localparam int IRQ_W = 2;

  // reset values
  localparam logic RST_GLOBAL = 1'b0;
  localparam logic RST_CTO_MASK = 1'b0;
  localparam logic [WAKE_W-1:0] RST_WAKE_EN = 8'h00;
  localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 2'h0;

  // responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    st_idle = 3'h1,
    st_low = 3'h2,
    st_guard = 3'h4
  } pulse_state_t;

endpackage

// ==== hdl/span_timer.sv ====
module span_timer #(
  parameter int WIDTH = 15
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic start,
  input wire logic [WIDTH-1:0] len,
  output logic busy,
  output logic done
);

  logic [WIDTH-1:0] count;

  // done marks the last cycle of a span of len enabled cycles
  assign done = busy && (count == '0);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count <= '0;
      busy <= 1'b0;
    end
    else if (ce)
    begin
      if (start)
      begin
        count <= len - WIDTH'(1);
        busy <= 1'b1;
      end
      else if (done)
        busy <= 1'b0;
      else if (busy)
        count <= count - WIDTH'(1);
    end
  end

endmodule // span_timer

// ==== verif/irq_mcu_model.sv ====
module irq_mcu_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic int_out,
  input wire logic int_oe_n,
  input wire logic cfg_high,
  output logic pin,
  output int pulse_cnt,
  output int low_len,
  output int gap_len
);
  timeunit 1ns;
  timeprecision 1ps;
  int run;
  logic pin_q;
  // strap level on released pin
  // cfg_high low leaves only the pull-down
  assign pin = int_oe_n ? cfg_high : int_out;
  // width of each low and high phase
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_q <= 1'b1;
      run <= 0;
      pulse_cnt <= 0;
      low_len <= 0;
      gap_len <= 0;
    end
    else if (pin !== pin_q)
    begin
      pin_q <= pin;
      run <= 1;
      if (!pin)
      begin
        pulse_cnt <= pulse_cnt + 1;
        gap_len <= run;
      end
      else
        low_len <= run;
    end
    else
      run <= run + 1;
  end
endmodule // irq_mcu_model

// ==== verif/sbc_interrupt_pulse_generator_tb_top.sv ====
`define CHK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      err_total++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end

module sbc_interrupt_pulse_generator_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PULSE = 20;
  localparam int GUARD = 10;
  localparam int SETTLE = PULSE + GUARD + 8;
  logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr, wk1, wk2, fails;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp;
  logic mode_normal, mode_stop, mode_init, stop_entry, cto, cfg_high;
  logic pin, int_out, int_oe_n, hw_config, irq;
  int err_total, checks_done, cyc, cnt, low_len, gap_len, n;

  irq_pulse_gen #(.PULSE_CYCLES(15'(PULSE)), .GUARD_CYCLES(15'(GUARD))) uut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .mode_normal(mode_normal), .mode_stop(mode_stop), .mode_init(mode_init),
    .stop_entry(stop_entry), .wake_event_one(wk1), .wake_event_two(wk2),
    .can_timeout_flag(cto), .fail_event(fails), .int_in(pin),
    .int_out(int_out), .int_oe_n(int_oe_n), .hw_config(hw_config),
    .irq(irq)
  );

  irq_mcu_model mcu (
    .aclk(aclk), .aresetn(aresetn), .int_out(int_out), .int_oe_n(int_oe_n),
    .cfg_high(cfg_high), .pin(pin), .pulse_cnt(cnt), .low_len(low_len),
    .gap_len(gap_len)
  );

  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic give_verdict;
    if (err_total == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // hang guard, well above the few thousand cycles needed
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 12000)
    begin
      err_total++;
      give_verdict;
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (!aw_ok && awready)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    `CHK(bresp, irq_pulse_pkg::RESP_OKAY)
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    rready <= 1'b0;
    `CHK(rresp, er)
  endtask

  task automatic fire(input logic [7:0] a, input logic [7:0] b,
                      input logic c, input logic [7:0] f);
    @(posedge aclk);
    wk1 <= a;
    wk2 <= b;
    cto <= c;
    fails <= f;
    @(posedge aclk);
    wk1 <= 8'h00;
    wk2 <= 8'h00;
    cto <= 1'b0;
    fails <= 8'h00;
  endtask

  task automatic settle;
    repeat (SETTLE) @(posedge aclk);
  endtask

  task automatic clear_all;
    wr(irq_pulse_pkg::OFF_WAKE_ONE, 32'hff);
    wr(irq_pulse_pkg::OFF_WAKE_TWO, 32'hff);
    wr(irq_pulse_pkg::OFF_FAIL, 32'h1ff);
  endtask

  task automatic t_reset;
    rd(irq_pulse_pkg::OFF_CTRL, irq_pulse_pkg::RESP_OKAY);
    `CHK(d[1:0], 2'h0)
    rd(irq_pulse_pkg::OFF_WAKE_EN, irq_pulse_pkg::RESP_OKAY);
    `CHK(d[15:0], 16'h0000)
    rd(irq_pulse_pkg::OFF_IRQ_MASK, irq_pulse_pkg::RESP_OKAY);
    `CHK(d[1:0], irq_pulse_pkg::RST_IRQ_MASK)
    `CHK({int_out, irq}, 2'h2)
    rd(8'h20, irq_pulse_pkg::RESP_SLVERR);
    `CHK(d, 32'h0)
    // idle, nothing pending, no configuration taken yet
    rd(irq_pulse_pkg::OFF_STATE, irq_pulse_pkg::RESP_OKAY);
    `CHK(d, 32'h1)
  endtask

  task automatic t_wake;
    wr(irq_pulse_pkg::OFF_WAKE_EN, 32'h1);
    wr(irq_pulse_pkg::OFF_IRQ_MASK, 32'h1);
    n = cnt;
    fire(8'h02, 8'h00, 1'b0, 8'h00);
    settle;
    `CHK(cnt, n)
    // latched but no pulse yet, so the readable copy stays old
    rd(irq_pulse_pkg::OFF_WAKE_ONE, irq_pulse_pkg::RESP_OKAY);
    `CHK(d[7:0], 8'h00)
    fire(8'h01, 8'h00, 1'b0, 8'h00);
    settle;
    `CHK(cnt, n + 1)
    `CHK(low_len, PULSE)
    `CHK(irq, 1'b1)
    rd(irq_pulse_pkg::OFF_WAKE_ONE, irq_pulse_pkg::RESP_OKAY);
    `CHK(d[1:0], 2'h3)
    rd(irq_pulse_pkg::OFF_IRQ_STAT, irq_pulse_pkg::RESP_OKAY);
    `CHK(d[0], 1'b1)
    `CHK(irq, 1'b0)
    wr(irq_pulse_pkg::OFF_WAKE_ONE, 32'hff);
    // second read confirms the clear took
    rd(irq_pulse_pkg::OFF_WAKE_ONE, irq_pulse_pkg::RESP_OKAY);
    `CHK(d[7:0], 8'h00)
    wr(irq_pulse_pkg::OFF_IRQ_MASK, 32'h0);
  endtask

  task automatic t_class;
    clear_all;
    n = cnt;
    fire(8'h00, 8'h00, 1'b0, 8'h01);
    settle;
    `CHK(cnt, n)
    wr(irq_pulse_pkg::OFF_FAIL, 32'h1ff);
    wr(irq_pulse_pkg::OFF_CTRL, 32'h1);
    fire(8'h00, 8'h00, 1'b0, 8'h01);
    settle;
    `CHK(cnt, n + 1)
    rd(irq_pulse_pkg::OFF_FAIL, irq_pulse_pkg::RESP_OKAY);
    `CHK(d[0], 1'b1)
    wr(irq_pulse_pkg::OFF_FAIL, 32'h1ff);
    wr(irq_pulse_pkg::OFF_CTRL, 32'h0);
    fire(8'h00, 8'h00, 1'b1, 8'h00);
    settle;
    `CHK(cnt, n + 2)
    wr(irq_pulse_pkg::OFF_FAIL, 32'h1ff);
    wr(irq_pulse_pkg::OFF_CTRL, 32'h3);
    fire(8'h00, 8'h00, 1'b1, 8'h00);
    settle;
    `CHK(cnt, n + 2)
    wr(irq_pulse_pkg::OFF_CTRL, 32'h0);
    clear_all;
  endtask

  task automatic t_pending;
    wr(irq_pulse_pkg::OFF_WAKE_EN, 32'h101);
    n = cnt;
    fire(8'h01, 8'h00, 1'b0, 8'h00);
    repeat (4) @(posedge aclk);
    fire(8'h00, 8'h01, 1'b0, 8'h00);
    fire(8'h01, 8'h00, 1'b0, 8'h00);
    settle;
    settle;
    `CHK(cnt, n + 2)
    `CHK(gap_len >= GUARD, 1'b1)
    `CHK(low_len, PULSE)
    clear_all;
  endtask

  task automatic t_stop;
    fire(8'h01, 8'h00, 1'b0, 8'h00);
    settle;
    n = cnt;
    // wake bit left set on purpose
    @(posedge aclk);
    stop_entry <= 1'b1;
    mode_stop <= 1'b1;
    mode_normal <= 1'b0;
    @(posedge aclk);
    stop_entry <= 1'b0;
    settle;
    `CHK(cnt, n + 1)
    `CHK({mode_stop, int_out}, 2'h3)
    clear_all;
    @(posedge aclk);
    mode_stop <= 1'b0;
    mode_normal <= 1'b1;
  endtask

  task automatic t_init;
    wr(irq_pulse_pkg::OFF_IRQ_MASK, 32'h2);
    @(posedge aclk);
    mode_init <= 1'b1;
    mode_normal <= 1'b0;
    cfg_high <= 1'b1;
    repeat (2) @(posedge aclk);
    `CHK(int_oe_n, 1'b1)
    n = cnt;
    fire(8'h01, 8'h00, 1'b0, 8'h00);
    repeat (1500) @(posedge aclk);
    `CHK(hw_config, 1'b1)
    `CHK(cnt, n)
    `CHK(irq, 1'b1)
    rd(irq_pulse_pkg::OFF_IRQ_STAT, irq_pulse_pkg::RESP_OKAY);
    `CHK(d[1], 1'b1)
    `CHK(irq, 1'b0)
    @(posedge aclk);
    mode_init <= 1'b0;
    mode_normal <= 1'b1;
    cfg_high <= 1'b0;
    repeat (2) @(posedge aclk);
    `CHK(int_oe_n, 1'b0)
  endtask

  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wk1, wk2, fails, wdata} = '0;
    {mode_stop, mode_init, stop_entry, cto, cfg_high} = 5'h0;
    mode_normal = 1'b1;
    ce = 1'b1;
    err_total = 0;
    checks_done = 0;
    cyc = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_wake;
    t_class;
    t_pending;
    t_stop;
    t_init;
    give_verdict;
  end
endmodule // sbc_interrupt_pulse_generator_tb_top
